//--- peg_pkg.sv
package peg_pkg;
   // ----------------------------------------------------------------
   // widths and ranges
   // ----------------------------------------------------------------
   localparam int GEAR_W = 17;                     // gear fields, 1..100000
   localparam int QUO_W = 18;                      // counts per pulse
   localparam int ERR_W = 32;                      // error counter width
   localparam logic [16:0] GEAR_MIN = 17'h00001;   // least gear value
   localparam logic [16:0] GEAR_MAX = 17'h186a0;   // 100000, largest gear value
   localparam logic [16:0] GEAR_RESET = 17'h00001; // reset value of gear fields

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_NUM_FIRST = 8'h00;  // gear_numerator_first
   localparam logic [7:0] ADDR_DEN = 8'h04;        // gear_denominator
   localparam logic [7:0] ADDR_NUM_SECOND = 8'h08; // gear_numerator_second
   localparam logic [7:0] ADDR_CFG = 8'h0c;        // mode and switch settings
   localparam logic [7:0] ADDR_RESTART = 8'h10;    // write bit 0 to restart
   localparam logic [7:0] ADDR_STATUS = 8'h14;     // live state, read only
   localparam logic [7:0] ADDR_ERROR = 8'h18;      // error counter, read only

   // ----------------------------------------------------------------
   // config register fields
   // ----------------------------------------------------------------
   localparam int CFG_MODE_LSB = 0;   // clear_mode_select, 2 bits
   localparam int CFG_GSE_BIT = 2;    // gear_switch_enable
   localparam int CFG_GSEQ_BIT = 3;   // gear_switch_sequence
   localparam int CFG_W = 4;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam int RESTART_BIT = 0;

   // ----------------------------------------------------------------
   // clear modes and switch sequences
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PEG_CLR_SERVO = 2'h0,   // clear on servo off
      PEG_CLR_NEVER = 2'h1,   // never clear automatically
      PEG_CLR_ALL = 2'h2,     // clear on servo off and over-travel, unless zero clamp
      PEG_CLR_RSVD = 2'h3     // reserved, behaves as never
   } peg_clr_mode_t;
   localparam logic GSEQ_IMMEDIATE = 1'b0;  // switch as soon as the pin moves
   localparam logic GSEQ_AT_REST = 1'b1;    // switch only at zero error, idle
endpackage

//--- peg_gear_scale.sv
`timescale 1ns/10ps
`default_nettype none
module peg_gear_scale #(
   parameter int GW = peg_pkg::GEAR_W,
   parameter int QW = peg_pkg::QUO_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // one reference pulse
   input wire logic start,
   input wire logic dir_rev,
   input wire logic [GW-1:0] num,
   input wire logic [GW-1:0] den,
   // scaled result
   output logic busy,
   output logic done,
   output logic [QW-1:0] quotient,
   output logic done_rev
);
   // ----------------------------------------------------------------
   // state and storage
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PEG_SC_IDLE = 2'b00,
      PEG_SC_RUN = 2'b01,
      PEG_SC_DONE = 2'b11
   } peg_sc_state_t;

   peg_sc_state_t state, next_state;
   logic [GW-1:0] frac, next_frac;          // remainder carried between pulses
   logic [QW-1:0] dividend, next_dividend;  // shifted numerator
   logic [QW-1:0] part, next_part;          // partial remainder
   logic [QW-1:0] quo, next_quo;            // quotient bits
   logic [4:0] step, next_step;             // divider step counter
   logic rev, next_rev;                     // direction of this pulse
   logic [QW:0] trial;                      // shifted partial remainder
   logic [GW-1:0] base;                     // remainder in direction frame

   // mirror a remainder into the reverse frame and back
   function automatic logic [GW-1:0] mirror(input logic [GW-1:0] d, input logic [GW-1:0] r);
      mirror = d - r - GW'(1);
   endfunction

   // ----------------------------------------------------------------
   // restoring divider: (frac + num) / den, one bit a cycle
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_frac = frac;
      next_dividend = dividend;
      next_part = part;
      next_quo = quo;
      next_step = step;
      next_rev = rev;
      base = dir_rev ? mirror(den, frac) : frac;
      trial = {part, dividend[QW-1]};
      case (state)
         PEG_SC_IDLE: begin
            if (start) begin
               // remainder enters the sum so no count is lost
               next_dividend = QW'(base) + QW'(num);
               next_part = '0;
               next_quo = '0;
               next_step = 5'(QW);
               next_rev = dir_rev;
               next_state = PEG_SC_RUN;
            end
         end
         PEG_SC_RUN: begin
            // subtract when the trial fits
            next_dividend = {dividend[QW-2:0], 1'b0};
            if (trial >= (QW+1)'(den)) begin
               next_part = QW'(trial - (QW+1)'(den));
               next_quo = {quo[QW-2:0], 1'b1};
            end else begin
               next_part = QW'(trial);
               next_quo = {quo[QW-2:0], 1'b0};
            end
            next_step = step - 5'h01;
            if (step == 5'h01) begin
               next_state = PEG_SC_DONE;
            end
         end
         PEG_SC_DONE: begin
            // keep the fraction for the next pulse
            next_frac = rev ? mirror(den, GW'(part)) : GW'(part);
            next_state = PEG_SC_IDLE;
         end
         default: begin
            next_state = PEG_SC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= PEG_SC_IDLE;
         frac <= '0;
         dividend <= '0;
         part <= '0;
         quo <= '0;
         step <= '0;
         rev <= 1'b0;
      end else begin
         state <= next_state;
         frac <= next_frac;
         dividend <= next_dividend;
         part <= next_part;
         quo <= next_quo;
         step <= next_step;
         rev <= next_rev;
      end
   end

   // result ports
   assign busy = (state != PEG_SC_IDLE);
   assign done = (state == PEG_SC_DONE);
   assign quotient = quo;
   assign done_rev = rev;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_launch;
      (state == PEG_SC_IDLE) && start;
   endsequence

   a_div_latency: assert property (s_launch |-> ##19 done)
      else $error("scaled result not ready 19 cycles after a pulse");
   // the dividend is loaded one edge after launch, so it lies 18 edges back
   a_div_exact: assert property (done |-> quo * QW'(den) + part == $past(dividend, 18))
      else $error("quotient and remainder do not rebuild the sum");
   a_rem_bound: assert property ((state == PEG_SC_IDLE) |-> frac < den)
      else $error("carried remainder reached the denominator");
endmodule
`default_nettype wire

//--- peg_top.sv
// Function
// - clear input low forces error count zero
// - while clearing, no position correction output
// - mode 0: clear on servo off only
// - mode 1: only the clear input clears
// - mode 2: servo off, over-travel, unless clamp
// - each pulse scaled by numerator over denominator
// - gear select low picks second numerator
// - select honoured only when switching enabled
// - gear values 1..100000, default 1, restart
`timescale 1ns/10ps
`default_nettype none
module peg_top #(
   parameter int GW = peg_pkg::GEAR_W,
   parameter int QW = peg_pkg::QUO_W,
   parameter int EW = peg_pkg::ERR_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins from the host controller
   input wire logic ref_step,
   input wire logic ref_dir,
   input wire logic error_clear_n,
   input wire logic gear_select_n,
   // drive-internal state
   input wire logic servo_on,
   input wire logic overtravel,
   input wire logic zero_clamp,
   input wire logic fb_step,
   input wire logic fb_dir,
   // position loop outputs
   output logic [EW-1:0] error_count,
   output logic [EW-1:0] pos_correction,
   output logic loop_active,
   output logic gear_second_active
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [3:0] sync1, sync2;        // pin synchronisers
   logic step_prev;                 // last synced step level
   logic pend, next_pend;           // pulse waiting for the scaler
   logic [GW-1:0] stage_num1, stage_den, stage_num2;  // written values
   logic [GW-1:0] next_stage_num1, next_stage_den, next_stage_num2;
   logic [GW-1:0] act_num1, act_den, act_num2;        // values in use
   logic [GW-1:0] next_act_num1, next_act_den, next_act_num2;
   logic [peg_pkg::CFG_W-1:0] cfg, next_cfg;          // settings
   peg_pkg::peg_clr_mode_t act_mode, next_act_mode;   // latched clear mode
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic [EW-1:0] next_error, next_corr;
   logic next_loop, next_second;
   logic wr_en, rd_en, restart;     // bus strobes
   logic clr_s, gsel_s, step_s, dir_s;  // synced pin levels
   logic step_edge, sc_start, auto_clr;
   logic sc_busy, sc_done, sc_rev;
   logic [QW-1:0] sc_quo;
   logic [GW-1:0] sc_num;

   // clamp a written gear value into its legal range
   function automatic logic [GW-1:0] clamp_gear(input logic [31:0] v);
      if (v < 32'(peg_pkg::GEAR_MIN)) begin
         clamp_gear = peg_pkg::GEAR_MIN;
      end else if (v > 32'(peg_pkg::GEAR_MAX)) begin
         clamp_gear = peg_pkg::GEAR_MAX;
      end else begin
         clamp_gear = GW'(v);
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1 <= 4'hf;
         sync2 <= 4'hf;
         step_prev <= 1'b1;
      end else begin
         sync1 <= {ref_step, ref_dir, error_clear_n, gear_select_n};
         sync2 <= sync1;
         step_prev <= sync2[3];
      end
   end

   assign step_s = sync2[3];
   assign dir_s = sync2[2];
   assign clr_s = sync2[1];
   assign gsel_s = sync2[0];
   assign step_edge = step_s && !step_prev;

   // ----------------------------------------------------------------
   // apb slave: one wait cycle, then pready
   // ----------------------------------------------------------------
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && !pready;
   assign restart = wr_en && (paddr == peg_pkg::ADDR_RESTART) && pwdata[peg_pkg::RESTART_BIT];

   always_comb begin
      next_pready = psel && penable && !pready;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      if (rd_en) begin
         next_prdata = '0;
         case (paddr)
            peg_pkg::ADDR_NUM_FIRST: next_prdata = 32'(stage_num1);
            peg_pkg::ADDR_DEN: next_prdata = 32'(stage_den);
            peg_pkg::ADDR_NUM_SECOND: next_prdata = 32'(stage_num2);
            peg_pkg::ADDR_CFG: next_prdata = 32'(cfg);
            peg_pkg::ADDR_RESTART: next_prdata = '0;
            peg_pkg::ADDR_STATUS: begin
               next_prdata = 32'({gear_second_active, loop_active, sc_busy, act_mode});
            end
            peg_pkg::ADDR_ERROR: next_prdata = 32'(error_count);
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------------------------------
   // settings: staged on write; gear values and clear mode taken into use at restart, gear switch bits at once
   // ----------------------------------------------------------------
   always_comb begin
      next_stage_num1 = stage_num1;
      next_stage_den = stage_den;
      next_stage_num2 = stage_num2;
      next_cfg = cfg;
      if (wr_en) begin
         case (paddr)
            peg_pkg::ADDR_NUM_FIRST: next_stage_num1 = clamp_gear(pwdata);
            peg_pkg::ADDR_DEN: next_stage_den = clamp_gear(pwdata);
            peg_pkg::ADDR_NUM_SECOND: next_stage_num2 = clamp_gear(pwdata);
            peg_pkg::ADDR_CFG: next_cfg = pwdata[peg_pkg::CFG_W-1:0];
            default: begin
               next_cfg = cfg;
            end
         endcase
      end
      // gear values and clear mode switch over only at restart
      next_act_num1 = restart ? stage_num1 : act_num1;
      next_act_den = restart ? stage_den : act_den;
      next_act_num2 = restart ? stage_num2 : act_num2;
      next_act_mode = restart ? peg_pkg::peg_clr_mode_t'(cfg[peg_pkg::CFG_MODE_LSB +: 2])
                              : act_mode;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stage_num1 <= peg_pkg::GEAR_RESET;
         stage_den <= peg_pkg::GEAR_RESET;
         stage_num2 <= peg_pkg::GEAR_RESET;
         act_num1 <= peg_pkg::GEAR_RESET;
         act_den <= peg_pkg::GEAR_RESET;
         act_num2 <= peg_pkg::GEAR_RESET;
         cfg <= peg_pkg::CFG_RESET;
         act_mode <= peg_pkg::PEG_CLR_SERVO;
      end else begin
         stage_num1 <= next_stage_num1;
         stage_den <= next_stage_den;
         stage_num2 <= next_stage_num2;
         act_num1 <= next_act_num1;
         act_den <= next_act_den;
         act_num2 <= next_act_num2;
         cfg <= next_cfg;
         act_mode <= next_act_mode;
      end
   end

   // ----------------------------------------------------------------
   // gear selection and pulse scaling
   // ----------------------------------------------------------------
   always_comb begin
      next_second = gear_second_active;
      if (!cfg[peg_pkg::CFG_GSE_BIT]) begin
         next_second = 1'b0;
      end else if (cfg[peg_pkg::CFG_GSEQ_BIT] == peg_pkg::GSEQ_IMMEDIATE) begin
         next_second = !gsel_s;
      end else if (error_count == '0 && !sc_busy && !pend) begin
         next_second = !gsel_s;
      end
      // one pulse may wait while the scaler is busy
      next_pend = (pend || step_edge) && sc_busy;
   end

   assign sc_start = (pend || step_edge) && !sc_busy;
   assign sc_num = gear_second_active ? act_num2 : act_num1;

   // divider turning one pulse into encoder counts
   peg_gear_scale #(
      .GW(GW),
      .QW(QW)
   ) u_scale (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(sc_start),
      .dir_rev(!dir_s),
      .num(sc_num),
      .den(act_den),
      .busy(sc_busy),
      .done(sc_done),
      .quotient(sc_quo),
      .done_rev(sc_rev)
   );

   // ----------------------------------------------------------------
   // error counter and position loop gate
   // ----------------------------------------------------------------
   always_comb begin
      auto_clr = 1'b0;
      case (act_mode)
         peg_pkg::PEG_CLR_SERVO: auto_clr = !servo_on;
         peg_pkg::PEG_CLR_ALL: auto_clr = (!servo_on || overtravel) && !zero_clamp;
         default: begin
            auto_clr = 1'b0;
         end
      endcase
      next_error = error_count;
      if (sc_done) begin
         next_error = sc_rev ? next_error - EW'(sc_quo) : next_error + EW'(sc_quo);
      end
      if (fb_step) begin
         next_error = fb_dir ? next_error - EW'(1) : next_error + EW'(1);
      end
      if (!clr_s || auto_clr) begin
         next_error = '0;
      end
      next_loop = clr_s && servo_on;
      next_corr = next_loop ? next_error : '0;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         error_count <= '0;
         pos_correction <= '0;
         loop_active <= 1'b0;
         gear_second_active <= 1'b0;
         pend <= 1'b0;
      end else begin
         error_count <= next_error;
         pos_correction <= next_corr;
         loop_active <= next_loop;
         gear_second_active <= next_second;
         pend <= next_pend;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_clear_zeroes: assert property (!clr_s |=> error_count == '0)
      else $error("error count not zero while clear held");
   a_clear_noloop: assert property (!clr_s |=> !loop_active && pos_correction == '0)
      else $error("correction produced while clear held");
   a_mode0_servo: assert property (act_mode == peg_pkg::PEG_CLR_SERVO && !servo_on |=> error_count == '0)
      else $error("mode 0 kept error at servo off");
   a_mode1_keep: assert property (act_mode == peg_pkg::PEG_CLR_NEVER && clr_s && !sc_done && !fb_step
                                  |=> error_count == $past(error_count))
      else $error("mode 1 changed error without cause");
   a_mode2_travel: assert property (act_mode == peg_pkg::PEG_CLR_ALL && overtravel && !zero_clamp
                                    |=> error_count == '0)
      else $error("mode 2 kept error at over-travel");
   a_gear_second: assert property (cfg[peg_pkg::CFG_GSE_BIT] && !cfg[peg_pkg::CFG_GSEQ_BIT] && !gsel_s
                                   |=> gear_second_active)
      else $error("second gear not chosen with select low");
   a_gear_disabled: assert property (!cfg[peg_pkg::CFG_GSE_BIT] |=> !gear_second_active)
      else $error("gear select honoured while switching off");
   a_restart_load: assert property (restart |=> act_den == $past(stage_den) && act_num1 == $past(stage_num1))
      else $error("restart did not take staged gear values");
   a_gear_range: assert property (stage_num1 >= peg_pkg::GEAR_MIN && stage_num1 <= peg_pkg::GEAR_MAX)
      else $error("first numerator outside its range");
endmodule
`default_nettype wire

//--- peg_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// host controller: one reference pulse per request
// ----------------------------------------------------------------
module peg_host_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // request from the bench
   input wire logic go,
   input wire logic go_rev,
   // pins towards the drive
   output logic ref_step,
   output logic ref_dir,
   output logic idle
);
   int cnt; // cycles into the current pulse

   // direction settles before the step edge, pulse 4 high, 30 cycle spacing
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         // idle levels, step low and direction forward
         ref_step <= 1'b0;
         ref_dir <= 1'b1;
         idle <= 1'b1;
         cnt <= 0;
      end else if (idle && go) begin
         idle <= 1'b0;
         ref_dir <= !go_rev;
         cnt <= 0;
      end else if (!idle) begin
         cnt <= cnt + 1;
         ref_step <= (cnt >= 2 && cnt < 6);
         if (cnt == 29) begin
            idle <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, er_s;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_s, error_count, pos_correction;
   logic ref_step, ref_dir, error_clear_n, gear_select_n, servo_on, overtravel;
   logic zero_clamp, fb_step, fb_dir, loop_active, gear_second_active, go, go_rev, idle;
   int err_count, checks;

   peg_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ref_step(ref_step), .ref_dir(ref_dir),
      .error_clear_n(error_clear_n), .gear_select_n(gear_select_n), .servo_on(servo_on),
      .overtravel(overtravel), .zero_clamp(zero_clamp), .fb_step(fb_step), .fb_dir(fb_dir),
      .error_count(error_count), .pos_correction(pos_correction),
      .loop_active(loop_active), .gear_second_active(gear_second_active));
   peg_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .go_rev(go_rev),
      .ref_step(ref_step),
      .ref_dir(ref_dir), .idle(idle));

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      chk32(nm, {31'h0, e}, {31'h0, g});
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // apb master and pin drivers
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // pready and read data are taken at the same rising edge
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_s = prdata;
      er_s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         results;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk32("prdata", e, rd_s);
   endtask

   // one reference pulse, waits for the host to go idle
   task automatic pulse(input logic r);
      int n;
      @(posedge sys_clk);
      go <= 1'b1;
      go_rev <= r;
      @(posedge sys_clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (idle !== 1'b1 && n < 60);
      if (n >= 60) begin
         err_count++;
         results;
      end
   endtask

   // bounded wait for the error counter, then compare
   task automatic wait_err(input logic [31:0] e);
      int n;
      n = 0;
      while (error_count !== e && n < 60) begin
         @(negedge sys_clk);
         n++;
      end
      chk32("error_count", e, error_count);
      if (n >= 60) begin
         results;
      end
   endtask

   // one feedback count, direction low adds one
   task automatic fb;
      @(posedge sys_clk);
      fb_step <= 1'b1;
      @(posedge sys_clk);
      fb_step <= 1'b0;
   endtask

   task automatic clr_pin(input logic v);
      @(posedge sys_clk);
      error_clear_n <= v;
      repeat (5) @(negedge sys_clk);
   endtask

   // gear select pin, driven on the rising edge, then settled
   task automatic gsel(input logic v);
      @(posedge sys_clk);
      gear_select_n <= v;
      repeat (5) @(negedge sys_clk);
   endtask

   // preload five counts, apply drive state, check kept or zeroed
   task automatic mode_case(input logic [1:0] m, input logic so, input logic ot,
                            input logic zc, input logic [31:0] e);
      wr(peg_pkg::ADDR_CFG, {30'h0, m});
      wr(peg_pkg::ADDR_RESTART, 32'h1);
      clr_pin(1'b0);
      clr_pin(1'b1);
      repeat (5) fb;
      wait_err(32'h5);
      @(posedge sys_clk);
      servo_on <= so;
      overtravel <= ot;
      zero_clamp <= zc;
      repeat (5) @(negedge sys_clk);
      chk32("error_count", e, error_count);
      @(posedge sys_clk);
      servo_on <= 1'b1;
      overtravel <= 1'b0;
      zero_clamp <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {sys_clk, rst_n, psel, penable, pwrite, go, go_rev, fb_step, fb_dir} = 9'h0;
      {overtravel, zero_clamp, paddr, pwdata} = 42'h0;
      {servo_on, error_clear_n, gear_select_n} = 3'h7;
      err_count = 0;
      checks = 0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk(peg_pkg::ADDR_NUM_FIRST, 32'h1);
      rdchk(peg_pkg::ADDR_DEN, 32'h1);
      rdchk(peg_pkg::ADDR_NUM_SECOND, 32'h1);
      rdchk(peg_pkg::ADDR_CFG, 32'h0);
      rdchk(8'h1c, 32'h0);
      chk1("pslverr", 1'b1, er_s);
      $display("test reset values done");
      pulse(1'b0);
      wait_err(32'h1);
      pulse(1'b0);
      pulse(1'b0);
      wait_err(32'h3);
      pulse(1'b1);
      wait_err(32'h2);
      repeat (3) @(negedge sys_clk);
      chk1("loop_active", 1'b1, loop_active);
      chk32("pos_correction", 32'h2, pos_correction);
      clr_pin(1'b0);
      chk32("error_count", 32'h0, error_count);
      chk1("loop_active", 1'b0, loop_active);
      chk32("pos_correction", 32'h0, pos_correction);
      fb;
      repeat (2) @(negedge sys_clk);
      chk32("error_count", 32'h0, error_count);
      clr_pin(1'b1);
      $display("test unit gear and clear done");
      wr(peg_pkg::ADDR_NUM_FIRST, 32'h3);
      wr(peg_pkg::ADDR_DEN, 32'h0);
      rdchk(peg_pkg::ADDR_DEN, 32'h1);
      wr(peg_pkg::ADDR_DEN, 32'h2);
      wr(peg_pkg::ADDR_NUM_SECOND, 32'h30d40);
      rdchk(peg_pkg::ADDR_NUM_SECOND, 32'h186a0);
      wr(peg_pkg::ADDR_NUM_SECOND, 32'h5);
      pulse(1'b0);
      wait_err(32'h1);
      wr(peg_pkg::ADDR_RESTART, 32'h1);
      pulse(1'b0);
      wait_err(32'h2);
      pulse(1'b0);
      wait_err(32'h4);
      pulse(1'b0);
      wait_err(32'h5);
      wr(peg_pkg::ADDR_CFG, 32'h4);
      gsel(1'b0);
      chk1("gear_second_active", 1'b1, gear_second_active);
      pulse(1'b0);
      wait_err(32'h8);
      gsel(1'b1);
      chk1("gear_second_active", 1'b0, gear_second_active);
      // at-rest sequence: the select waits for a zero error
      wr(peg_pkg::ADDR_CFG, 32'hc);
      gsel(1'b0);
      chk1("gear_second_active", 1'b0, gear_second_active);
      clr_pin(1'b0);
      chk1("gear_second_active", 1'b1, gear_second_active);
      wr(peg_pkg::ADDR_CFG, 32'h0);
      repeat (2) @(negedge sys_clk);
      chk1("gear_second_active", 1'b0, gear_second_active);
      $display("test gear scaling and switching done");
      mode_case(2'h0, 1'b1, 1'b1, 1'b0, 32'h5);
      mode_case(2'h0, 1'b0, 1'b0, 1'b0, 32'h0);
      mode_case(2'h1, 1'b0, 1'b1, 1'b0, 32'h5);
      mode_case(2'h2, 1'b1, 1'b1, 1'b0, 32'h0);
      mode_case(2'h2, 1'b0, 1'b0, 1'b0, 32'h0);
      mode_case(2'h2, 1'b0, 1'b1, 1'b1, 32'h5);
      $display("test clear modes done");
      results;
   end

   // run limit
   initial begin
      repeat (100000) @(posedge sys_clk);
      err_count++;
      results;
   end
endmodule
`default_nettype wire
